// ### design/uss_defs.svh
`ifndef USS_DEFS_SVH
`define USS_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define USS_ADDR_DATA 4'h0
`define USS_ADDR_STATUS 4'h4
`define USS_ADDR_CONTROL 4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define USS_ST_START 7
`define USS_ST_OVF 6
`define USS_ST_STOP 5
`define USS_ST_COLL 4
`define USS_ST_CNT_HI 3
`define USS_ST_CNT_LO 0
`define USS_CT_SIE 7
`define USS_CT_OIE 6
`define USS_CT_WM_HI 5
`define USS_CT_WM_LO 4
`define USS_CT_CS_HI 3
`define USS_CT_CS_LO 2
`define USS_CT_CLK 1
`define USS_CT_TC 0

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define USS_WM_OFF 2'h0
`define USS_WM_THREE 2'h1
`define USS_WM_TWO 2'h2
`define USS_WM_TWO_HOLD 2'h3
`define USS_CS_SOFT 2'h0
`define USS_CS_TIMER 2'h1
`define USS_CS_EXT_POS 2'h2
`define USS_CS_EXT_NEG 2'h3
`define USS_RESET_BYTE 8'h00
`define USS_COUNT_MAX 4'hf
`define USS_PIN_IDLE 1'b1
`define USS_RESP_OKAY 2'h0
`define USS_RESP_SLVERR 2'h2

`endif

// ### design/uss_pkg.sv
`include "uss_defs.svh"

package uss_pkg;

    typedef enum logic [1:0] {
        USS_MODE_OFF = `USS_WM_OFF,
        USS_MODE_THREE = `USS_WM_THREE,
        USS_MODE_TWO_HOLD = `USS_WM_TWO_HOLD,
        USS_MODE_TWO = `USS_WM_TWO
    } uss_wire_mode_e;

    typedef logic [1:0] uss_clk_sel_t;

endpackage

// ### design/uss_sync.sv
`timescale 1ns/1ps
`include "uss_defs.svh"

module uss_sync
    import uss_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] pin_async,
    output logic [1:0] pin_level,
    output logic [1:0] pin_rise,
    output logic [1:0] pin_fall
);

    // Lines idle high, so reset to that level to avoid a false edge.
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            logic prev_reg;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_reg <= `USS_PIN_IDLE;
                    sync_reg <= `USS_PIN_IDLE;
                    prev_reg <= `USS_PIN_IDLE;
                end else begin
                    meta_reg <= pin_async[i];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end
            assign pin_level[i] = sync_reg;
            assign pin_rise[i] = sync_reg & ~prev_reg;
            assign pin_fall[i] = ~sync_reg & prev_reg;
        end
    endgenerate

endmodule

// ### design/uss_regs.sv
// Operation
// - Data register reads and writes the live shifter
// - CPU data write beats a coincident shift
// - Shift left on the selected clock source
// - Pin inputs feed shifter with outputs off
// - Active output pin follows bit 7 via latch
// - Latch half-transparent external, always transparent internal
// - Open latch shows new MSB, opposite edges
// - Pin driven only when direction bit set
// - Status layout start, overflow, stop, collision, count
// - Two-wire start condition sets start flag
// - Other modes, external select, clock bit clear: clock pin edge sets flag
// - Start flag interrupt, write-one clear releases hold
// - Start wakes always, overflow wakes idle only
// - Wrap sets overflow flag, write-one clears hold
// - Two-wire stop sets stop flag, no interrupt
// - Collision when bit 7 differs from pin
// - Counter readable and writable through status
// - Counter increments on the selected clock
// - External select plus clock bit: toggle counts
// - Control layout enables, mode, select, strobes
// - Pending flag interrupts once enables are set
// - Wire mode changes outputs and start/stop detection
// - Wire mode encoding, two-wire hold mode holds clock after overflow
// - Soft select: clock bit strobes both once
`timescale 1ns/1ps
`include "uss_defs.svh"

module uss_regs
    import uss_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin,
    input wire logic data_in_pin,
    input wire logic timer0_overflow,
    input wire logic global_irq_enable,
    input wire logic idle_sleep_active,
    input wire logic do_dir_bit,
    input wire logic sda_dir_bit,
    input wire logic sda_port_bit,
    input wire logic scl_dir_bit,
    input wire logic scl_port_bit,
    output logic data_out_pin,
    output logic data_out_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic start_irq,
    output logic overflow_irq,
    output logic wake_request
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [3:0] aw_addr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic [3:0] rd_addr_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [7:0] rdata_reg;
    logic [7:0] data_reg, data_next, data_shl;
    logic [3:0] count_reg, count_plus;
    logic start_flag_reg, ovf_flag_reg, stop_flag_reg;
    logic start_en_reg, ovf_en_reg, sw_clk_sel_reg;
    uss_wire_mode_e wire_mode_reg;
    uss_clk_sel_t clk_sel_reg;
    logic latch_reg, latch_next, transparent;
    logic start_hold_reg, ovf_hold;
    logic do_out_reg, do_oe_reg, sda_oe_reg, scl_oe_reg;
    logic start_irq_reg, ovf_irq_reg, wake_reg;
    logic [1:0] pin_level, pin_rise, pin_fall;
    logic scl_level, scl_rise, scl_fall, sda_level, sda_rise, sda_fall;
    logic wr_fire, wr_data, wr_status, wr_ctl, wr_hit;
    logic sw_strobe, tc_strobe, shift_tick, count_tick;
    logic two_wire, start_det, stop_det, ovf_event, collision;
    logic start_clr, ovf_clr, stop_clr;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    uss_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async({data_in_pin, serial_clock_pin}),
        .pin_level(pin_level),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall)
    );

    assign scl_level = pin_level[0];
    assign scl_rise = pin_rise[0];
    assign scl_fall = pin_fall[0];
    assign sda_level = pin_level[1];
    assign sda_rise = pin_rise[1];
    assign sda_fall = pin_fall[1];

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // The write is performed once both address and data are held.
    assign wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
    assign wr_hit = wr_fire & wstrb0_reg;
    assign wr_data = wr_hit && aw_addr_reg == `USS_ADDR_DATA;
    assign wr_status = wr_hit && aw_addr_reg == `USS_ADDR_STATUS;
    assign wr_ctl = wr_hit && aw_addr_reg == `USS_ADDR_CONTROL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `USS_RESP_OKAY;
            aw_addr_reg <= 4'h0;
            wdata_reg <= `USS_RESET_BYTE;
            wstrb0_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                if (aw_addr_reg == `USS_ADDR_DATA ||
                    aw_addr_reg == `USS_ADDR_STATUS ||
                    aw_addr_reg == `USS_ADDR_CONTROL) begin
                    bresp_reg <= `USS_RESP_OKAY;
                end else begin
                    bresp_reg <= `USS_RESP_SLVERR;
                end
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Reads have no side effect; the data word is the live shifter.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= `USS_RESET_BYTE;
            rresp_reg <= `USS_RESP_OKAY;
            rd_addr_reg <= 4'h0;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rd_addr_reg <= s_axi_araddr;
            rresp_reg <= `USS_RESP_OKAY;
            if (s_axi_araddr == `USS_ADDR_DATA) begin
                rdata_reg <= data_reg;
            end else if (s_axi_araddr == `USS_ADDR_STATUS) begin
                rdata_reg <= {start_flag_reg, ovf_flag_reg, stop_flag_reg,
                              collision, count_reg};
            end else if (s_axi_araddr == `USS_ADDR_CONTROL) begin
                rdata_reg <= {start_en_reg, ovf_en_reg, wire_mode_reg,
                              clk_sel_reg, 2'b00};
            end else begin
                rdata_reg <= `USS_RESET_BYTE;
                rresp_reg <= `USS_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_en_reg <= 1'b0;
            ovf_en_reg <= 1'b0;
            wire_mode_reg <= USS_MODE_OFF;
            clk_sel_reg <= `USS_CS_SOFT;
            sw_clk_sel_reg <= 1'b0;
        end else if (wr_ctl) begin
            start_en_reg <= wdata_reg[`USS_CT_SIE];
            ovf_en_reg <= wdata_reg[`USS_CT_OIE];
            wire_mode_reg <= uss_wire_mode_e'(
                wdata_reg[`USS_CT_WM_HI:`USS_CT_WM_LO]);
            clk_sel_reg <= wdata_reg[`USS_CT_CS_HI:`USS_CT_CS_LO];
            // The clock bit doubles as a source selector for the counter.
            sw_clk_sel_reg <= wdata_reg[`USS_CT_CLK];
        end
    end

    // ****************************************************************
    // Clock sources
    // ****************************************************************
    assign sw_strobe = wr_ctl & wdata_reg[`USS_CT_CLK] &
        (wdata_reg[`USS_CT_CS_HI:`USS_CT_CS_LO] == `USS_CS_SOFT);
    assign tc_strobe = wr_ctl & wdata_reg[`USS_CT_TC];

    // Pin inputs act in every wire mode, including outputs off.
    always_comb begin
        case (clk_sel_reg)
            `USS_CS_SOFT: shift_tick = sw_strobe;
            `USS_CS_TIMER: shift_tick = timer0_overflow;
            `USS_CS_EXT_POS: shift_tick = scl_rise;
            default: shift_tick = scl_fall;
        endcase
    end

    always_comb begin
        case (clk_sel_reg)
            `USS_CS_SOFT: count_tick = sw_strobe;
            `USS_CS_TIMER: count_tick = timer0_overflow;
            default: count_tick = sw_clk_sel_reg ? tc_strobe :
                (scl_rise | scl_fall);
        endcase
    end

    // ****************************************************************
    // Shift register and counter
    // ****************************************************************
    assign data_shl = {data_reg[6:0], sda_level};
    assign count_plus = count_reg + 4'h1;

    always_comb begin
        if (wr_data) begin
            data_next = wdata_reg;
        end else if (shift_tick) begin
            data_next = data_shl;
        end else begin
            data_next = data_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg <= `USS_RESET_BYTE;
        end else begin
            data_reg <= data_next;
        end
    end

    // A CPU load of the count wins over a coincident tick.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 4'h0;
        end else if (wr_status) begin
            count_reg <= wdata_reg[`USS_ST_CNT_HI:`USS_ST_CNT_LO];
        end else if (count_tick) begin
            count_reg <= count_plus;
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    assign two_wire = wire_mode_reg[1];
    assign start_det = (two_wire & sda_fall & scl_level) |
        (~two_wire & clk_sel_reg[1] & ~sw_clk_sel_reg &
         (scl_rise | scl_fall));
    assign stop_det = two_wire & sda_rise & scl_level;
    assign ovf_event = count_tick & ~wr_status &
        (count_reg == `USS_COUNT_MAX);
    assign collision = data_reg[7] ^ sda_level;
    assign start_clr = wr_status & wdata_reg[`USS_ST_START];
    assign ovf_clr = wr_status & wdata_reg[`USS_ST_OVF];
    assign stop_clr = wr_status & wdata_reg[`USS_ST_STOP];

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_flag_reg <= 1'b0;
            ovf_flag_reg <= 1'b0;
            stop_flag_reg <= 1'b0;
        end else begin
            start_flag_reg <= start_det | (start_flag_reg & ~start_clr);
            ovf_flag_reg <= ovf_event | (ovf_flag_reg & ~ovf_clr);
            stop_flag_reg <= stop_det | (stop_flag_reg & ~stop_clr);
        end
    end

    // The hold starts when the master pulls clock low after a start.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_hold_reg <= 1'b0;
        end else if (!two_wire || (start_clr && !start_det)) begin
            start_hold_reg <= 1'b0;
        end else if (start_flag_reg && scl_fall) begin
            start_hold_reg <= 1'b1;
        end
    end

    assign ovf_hold = (wire_mode_reg == USS_MODE_TWO_HOLD) &
        ovf_flag_reg;

    // ****************************************************************
    // Output latch and pins
    // ****************************************************************
    // Externally clocked, the latch opens in the half opposite the
    // sampling edge, so output and input never change together.
    assign transparent = ~clk_sel_reg[1] |
        (scl_level == clk_sel_reg[0]);
    assign latch_next = transparent ? data_next[7] : latch_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            do_out_reg <= 1'b0;
            do_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
        end else begin
            do_out_reg <= latch_next;
            do_oe_reg <= (wire_mode_reg == USS_MODE_THREE) &
                do_dir_bit;
            sda_oe_reg <= two_wire & sda_dir_bit &
                (~latch_next | ~sda_port_bit);
            scl_oe_reg <= two_wire & scl_dir_bit &
                (~scl_port_bit | start_hold_reg | ovf_hold);
        end
    end

    // ****************************************************************
    // Interrupt requests and wake-up
    // ****************************************************************
    // The stop flag deliberately has no request path.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_irq_reg <= 1'b0;
            ovf_irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            start_irq_reg <= start_flag_reg & start_en_reg &
                global_irq_enable;
            ovf_irq_reg <= ovf_flag_reg & ovf_en_reg &
                global_irq_enable;
            wake_reg <= (start_flag_reg & start_en_reg &
                global_irq_enable) | (ovf_flag_reg & ovf_en_reg &
                global_irq_enable & idle_sleep_active);
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};
    assign data_out_pin = do_out_reg;
    assign data_out_oe = do_oe_reg;
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign scl_out = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign start_irq = start_irq_reg;
    assign overflow_irq = ovf_irq_reg;
    assign wake_request = wake_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_beats_shift: assert property (
        wr_data |=> data_reg == $past(wdata_reg))
        else $error("data write lost to a shift");
    a_shift_left: assert property (
        shift_tick && !wr_data |=> data_reg == $past(data_shl))
        else $error("shift did not move data left");
    a_count_step: assert property (
        count_tick && !wr_status |=> count_reg == $past(count_plus))
        else $error("counter did not step by one");
    a_wrap_sets_ovf: assert property (
        ovf_event |=> ovf_flag_reg)
        else $error("wrap did not set overflow flag");
    a_stop_two_wire: assert property (
        $rose(stop_flag_reg) |-> $past(two_wire))
        else $error("stop flag set outside two-wire mode");
    a_pending_irq: assert property (
        start_flag_reg && start_en_reg && global_irq_enable |=> start_irq)
        else $error("pending start flag gave no request");
    a_strobe_reads_zero: assert property (
        rvalid_reg && rd_addr_reg == `USS_ADDR_CONTROL
        |-> rdata_reg[1:0] == 2'b00)
        else $error("strobe bits read back nonzero");
    a_do_needs_dir: assert property (
        data_out_oe |-> $past(do_dir_bit))
        else $error("data output driven without direction bit");
    a_ovf_hold_scl: assert property (
        wire_mode_reg == USS_MODE_TWO_HOLD && ovf_flag_reg && scl_dir_bit
        |=> scl_oe)
        else $error("clock line not held after overflow");
    a_latch_closed: assert property (
        clk_sel_reg[1] && (scl_level != clk_sel_reg[0])
        |=> latch_reg == $past(latch_reg))
        else $error("closed latch changed");
    a_start_sticky: assert property (
        start_flag_reg && !start_clr |=> start_flag_reg)
        else $error("start flag cleared without write");

    c_overflow: cover property (ovf_event);
    c_two_wire_start: cover property (two_wire && start_det);
    c_stop: cover property (stop_det);
    c_write_vs_shift: cover property (wr_data && shift_tick);

endmodule

// ### testbench/uss_far_end.sv
`timescale 1ns/1ps
module uss_far_end (
    output logic serial_clock_pin,
    output logic data_in_pin
);
    // The clock rests high between frames, the synchroniser's reset level,
    // so no false edge follows reset. The data line is low until the first
    // frame, then released to its pull-up with the clock high. Data bits change while clock is low.
    initial begin
        serial_clock_pin = 1'b1;
        data_in_pin = 1'b0;
    end
    task automatic send_byte(input logic [7:0] b);
        #3;
        for (int i = 7; i >= 0; i--) begin
            #80 serial_clock_pin = 1'b0;
            data_in_pin = b[i];
            #80 serial_clock_pin = 1'b1;
        end
        #80 data_in_pin = 1'b1;
    endtask
    // Start: data falls while the clock is high, then the clock falls.
    task automatic start_cond;
        #3 data_in_pin = 1'b0;
        #80 serial_clock_pin = 1'b0;
    endtask
    // Stop: the clock rises, then data rises while the clock is high.
    task automatic stop_cond;
        #3 serial_clock_pin = 1'b1;
        #80 data_in_pin = 1'b1;
    endtask
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "uss_defs.svh"
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, timer0_overflow = 1'b0;
    logic global_irq_enable = 1'b0, idle_sleep_active = 1'b0;
    logic do_dir_bit = 1'b1, sda_dir_bit = 1'b0, sda_port_bit = 1'b1;
    logic scl_dir_bit = 1'b0, scl_port_bit = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, data_out_pin, data_out_oe, sda_out, sda_oe;
    logic scl_out, scl_oe, start_irq, overflow_irq, wake_request;
    logic serial_clock_pin, data_in_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata;
    int err_count = 0;
    int cmp_count = 0;

    uss_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_pin,
        .data_in_pin, .timer0_overflow, .global_irq_enable,
        .idle_sleep_active, .do_dir_bit, .sda_dir_bit, .sda_port_bit,
        .scl_dir_bit, .scl_port_bit, .data_out_pin, .data_out_oe, .sda_out,
        .sda_oe, .scl_out, .scl_oe, .start_irq, .overflow_irq, .wake_request);
    uss_far_end far (.serial_clock_pin, .data_in_pin);

    always #5 aclk = ~aclk;

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // The wr and rd_chk tasks first let an edge pass, so a strobe lowered by the
    // previous call is never raised again in the same time step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, er}, n < 50 ? {30'h0, s_axi_bresp} : 32'hx);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [7:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        rr = s_axi_rresp;
        check(nm, {24'h0, e}, n < 50 ? s_axi_rdata : 32'hx);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // The collision bit is live, so let the data line pass the
        // synchroniser before the reset value of status is read.
        repeat (2) @(posedge aclk);
        rd_chk("status", `USS_ADDR_STATUS, 8'h00);
        rd_chk("control", `USS_ADDR_CONTROL, 8'h00);
        wr(`USS_ADDR_CONTROL, 8'h10, `USS_RESP_OKAY);
        wr(`USS_ADDR_DATA, 8'ha5, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("data_out_pin", 32'h1, {31'h0, data_out_pin});
        check("data_out_oe", 32'h1, {31'h0, data_out_oe});
        rd_chk("data", `USS_ADDR_DATA, 8'ha5);
        rd_chk("collision", `USS_ADDR_STATUS, 8'h10);
        wr(`USS_ADDR_CONTROL, 8'h12, `USS_RESP_OKAY);
        rd_chk("shifted", `USS_ADDR_DATA, 8'h4a);
        rd_chk("count", `USS_ADDR_STATUS, 8'h01);
        rd_chk("strobes", `USS_ADDR_CONTROL, 8'h10);
        check("new_msb", 32'h0, {31'h0, data_out_pin});
        do_dir_bit <= 1'b0;
        repeat (3) @(posedge aclk);
        check("oe_off", 32'h0, {31'h0, data_out_oe});
        wr(`USS_ADDR_STATUS, 8'h0f, `USS_RESP_OKAY);
        wr(`USS_ADDR_CONTROL, 8'h14, `USS_RESP_OKAY);
        rd_chk("count_wr", `USS_ADDR_STATUS, 8'h0f);
        timer0_overflow <= 1'b1;
        @(posedge aclk);
        timer0_overflow <= 1'b0;
        rd_chk("timer_data", `USS_ADDR_DATA, 8'h94);
        rd_chk("wrap", `USS_ADDR_STATUS, 8'h50);
        global_irq_enable <= 1'b1;
        idle_sleep_active <= 1'b1;
        wr(`USS_ADDR_CONTROL, 8'h54, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("ovf_irq", 32'h1, {31'h0, overflow_irq});
        check("ovf_wake", 32'h1, {31'h0, wake_request});
        wr(`USS_ADDR_STATUS, 8'h40, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("ovf_clear", 32'h0, {31'h0, overflow_irq});
        idle_sleep_active <= 1'b0;
        wr(`USS_ADDR_CONTROL, 8'h08, `USS_RESP_OKAY);
        far.send_byte(8'hc3);
        repeat (10) @(posedge aclk);
        rd_chk("frame_data", `USS_ADDR_DATA, 8'hc3);
        rd_chk("frame_status", `USS_ADDR_STATUS, 8'hc0);
        wr(`USS_ADDR_CONTROL, 8'h88, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("start_irq", 32'h1, {31'h0, start_irq});
        check("start_wake", 32'h1, {31'h0, wake_request});
        wr(`USS_ADDR_STATUS, 8'hc0, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("start_clear", 32'h0, {31'h0, start_irq});
        wr(4'hc, 8'h55, `USS_RESP_SLVERR);
        rd_chk("unmapped", 4'hc, 8'h00);
        check("rresp", {30'h0, `USS_RESP_SLVERR}, {30'h0, rr});
        sda_dir_bit <= 1'b1;
        scl_dir_bit <= 1'b1;
        wr(`USS_ADDR_CONTROL, 8'h20, `USS_RESP_OKAY);
        far.start_cond;
        repeat (6) @(posedge aclk);
        check("scl_hold", 32'h1, {31'h0, scl_oe});
        check("sda_free", 32'h0, {31'h0, sda_oe});
        check("lines_out", 32'h0, {30'h0, sda_out, scl_out});
        rd_chk("start_2w", `USS_ADDR_STATUS, 8'h90);
        wr(`USS_ADDR_STATUS, 8'h80, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("scl_free", 32'h0, {31'h0, scl_oe});
        far.stop_cond;
        repeat (6) @(posedge aclk);
        rd_chk("stop_2w", `USS_ADDR_STATUS, 8'h20);
        wr(`USS_ADDR_STATUS, 8'h0f, `USS_RESP_OKAY);
        wr(`USS_ADDR_CONTROL, 8'h32, `USS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("ovf_hold", 32'h1, {31'h0, scl_oe});
        give_verdict;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #200000;
        err_count++;
        give_verdict;
    end
endmodule
